// file: design/bsx_cfg.svh
// What this block does
// - Opcode 0x4F takes six cycles and clears flag bit 0, the bank select, choosing bank 0.
// - Opcode 0x5F takes six cycles and sets flag bit 0, the bank select, to one.
// - Set 1 register accesses go to bank 1 while bank select is one and bank 1 exists, else bank 0.
// - Both bank select instructions leave carry, zero, sign, overflow, decimal and half flags alone.
// - Subtract with borrow writes destination minus source minus carry back to the destination only.
// - The subtraction adds the two's complement of the source, with carry acting as a borrow.
// - Carry is set after subtract with borrow when a borrow occurred, else cleared.
// - Zero is set when the 8-bit result is zero, else cleared.
// - Sign is set when result bit 7 is one, else cleared.
// - Overflow is set when operand signs differ and the result sign equals the source sign.
// - Decimal adjust is forced to one after subtract with borrow.
// - Half carry is cleared on a carry out of bit 3 and set otherwise, marking a nibble borrow.
`ifndef BSX_CFG_SVH
`define BSX_CFG_SVH

// ----------------------------------------------------------------
// Opcodes and timing
// ----------------------------------------------------------------
`define BSX_OPC_SEL_BANK0 8'h4F
`define BSX_OPC_SEL_BANK1 8'h5F
`define BSX_BANK_CYCLES 4'h6
`define BSX_SBC_CYCLES 4'h6
`define BSX_BANK1_PRESENT 1'b1

// ----------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------
`define BSX_FLG_C 7
`define BSX_FLG_Z 6
`define BSX_FLG_S 5
`define BSX_FLG_V 4
`define BSX_FLG_D 3
`define BSX_FLG_H 2
`define BSX_FLG_BANK 0
`define BSX_FLG_RESET 8'h00
`define BSX_FLG_WMASK 8'hFD

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BSX_REG_FLAGS 4'h0
`define BSX_REG_STATUS 4'h1
`define BSX_REG_RESULT 4'h2

`endif

// file: design/bsx_pkg.sv
package bsx_pkg;
	// Execution states of the core slice
	typedef enum logic [1:0] {
		st_idle,
		st_busy
	} bsx_state_t;

	// Instruction being executed
	typedef enum logic [1:0] {
		op_none,
		op_sel_bank0,
		op_sel_bank1,
		op_sub_borrow
	} bsx_op_t;
endpackage : bsx_pkg

// file: design/bsx_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
// Operands in, result and flags out of the subtract datapath
interface bsx_alu_if;
	logic [7:0] dst;
	logic [7:0] src;
	logic cin;
	logic [7:0] res;
	logic c;
	logic z;
	logic s;
	logic v;
	logic h;
	modport alu (input dst, input src, input cin, output res, output c, output z,
		output s, output v, output h);
	modport core (output dst, output src, output cin, input res, input c, input z,
		input s, input v, input h);
endinterface : bsx_alu_if
`default_nettype wire

// file: design/bsx_sbc_alu.sv
`timescale 1ns/1ps
`default_nettype none
// Combinational subtract-with-borrow datapath
module bsx_sbc_alu (
	// Operands and results
	bsx_alu_if.alu io
);
	logic [8:0] sum;
	logic [4:0] nib;

	// Add inverted source plus inverted borrow: two's complement subtraction
	always_comb
	begin
		sum = {1'b0, io.dst} + {1'b0, ~io.src} + {8'h00, ~io.cin};
		nib = {1'b0, io.dst[3:0]} + {1'b0, ~io.src[3:0]} + {4'h0, ~io.cin};
	end

	assign io.res = sum[7:0];
	assign io.c = ~sum[8]; // No carry out means a borrow
	assign io.z = (sum[7:0] == 8'h00);
	assign io.s = sum[7];
	assign io.v = (io.dst[7] != io.src[7]) && (sum[7] == io.src[7]);
	assign io.h = ~nib[4]; // Carry out of bit 3 clears it
endmodule : bsx_sbc_alu
`default_nettype wire

// file: design/bsx_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsx_cfg.svh"
// Bank select and subtract-with-borrow execution slice
module bsx_core (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_ff,
	// Instruction issue
	input wire logic ins_valid,
	input wire logic [7:0] ins_opcode,
	input wire logic ins_sbc,
	input wire logic [7:0] ins_dst,
	input wire logic [7:0] ins_src,
	// Execution results
	output logic busy_ff,
	output logic done_ff,
	output logic dst_we_ff,
	output logic [7:0] dst_wdata_ff,
	output logic [7:0] flags_ff,
	output logic set1_bank_ff
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	bsx_pkg::bsx_state_t state_ff;
	bsx_pkg::bsx_op_t op_ff;
	bsx_pkg::bsx_op_t nxt_op;
	logic [3:0] cnt_ff;
	logic [7:0] dst_ff;
	logic [7:0] src_ff;
	logic accept;
	logic finish;
	logic [7:0] nxt_flags;
	bsx_alu_if alu_bus ();

	// ----------------------------------------------------------------
	// Decode and sequencing
	// ----------------------------------------------------------------
	// Unknown opcodes are dropped: nothing outside this slice is decoded here
	always_comb
	begin
		if (ins_sbc)
			nxt_op = bsx_pkg::op_sub_borrow;
		else if (ins_opcode == `BSX_OPC_SEL_BANK0)
			nxt_op = bsx_pkg::op_sel_bank0;
		else if (ins_opcode == `BSX_OPC_SEL_BANK1)
			nxt_op = bsx_pkg::op_sel_bank1;
		else
			nxt_op = bsx_pkg::op_none;
	end

	assign accept = ins_valid && (state_ff == bsx_pkg::st_idle) && (nxt_op != bsx_pkg::op_none);
	assign finish = (state_ff == bsx_pkg::st_busy) && (cnt_ff == 4'h1);

	// State and cycle counter; the accept cycle counts as the first of six
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff <= bsx_pkg::st_idle;
			cnt_ff <= 4'h0;
			op_ff <= bsx_pkg::op_none;
		end
		else
		begin
			case (state_ff)
				bsx_pkg::st_idle:
				begin
					if (accept)
					begin
						state_ff <= bsx_pkg::st_busy;
						op_ff <= nxt_op;
						if (nxt_op == bsx_pkg::op_sub_borrow)
							cnt_ff <= `BSX_SBC_CYCLES - 4'h1;
						else
							cnt_ff <= `BSX_BANK_CYCLES - 4'h1;
					end
				end
				bsx_pkg::st_busy:
				begin
					if (finish)
						state_ff <= bsx_pkg::st_idle;
					else
						cnt_ff <= cnt_ff - 4'h1;
				end
				default:
					state_ff <= bsx_pkg::st_idle;
			endcase
		end
	end

	// Operand capture so the datapath sees stable inputs for the whole instruction
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dst_ff <= 8'h00;
			src_ff <= 8'h00;
		end
		else if (accept)
		begin
			dst_ff <= ins_dst;
			src_ff <= ins_src;
		end
	end

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	assign alu_bus.dst = dst_ff;
	assign alu_bus.src = src_ff;
	assign alu_bus.cin = flags_ff[`BSX_FLG_C]; // Carry in taken at completion time

	bsx_sbc_alu bsx_sbc_alu_inst (
		.io(alu_bus.alu)
	);

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	// Completion wins over a software write in the same cycle so no result is lost
	always_comb
	begin
		nxt_flags = flags_ff;
		if (finish)
		begin
			case (op_ff)
				bsx_pkg::op_sel_bank0:
					nxt_flags[`BSX_FLG_BANK] = 1'b0; // Only bank bit moves
				bsx_pkg::op_sel_bank1:
					nxt_flags[`BSX_FLG_BANK] = 1'b1;
				bsx_pkg::op_sub_borrow:
				begin
					nxt_flags[`BSX_FLG_C] = alu_bus.c;
					nxt_flags[`BSX_FLG_Z] = alu_bus.z;
					nxt_flags[`BSX_FLG_S] = alu_bus.s;
					nxt_flags[`BSX_FLG_V] = alu_bus.v;
					nxt_flags[`BSX_FLG_D] = 1'b1;
					nxt_flags[`BSX_FLG_H] = alu_bus.h;
				end
				default:
					nxt_flags = flags_ff;
			endcase
		end
		else if (reg_wr && (reg_addr == `BSX_REG_FLAGS))
			nxt_flags = reg_wdata & `BSX_FLG_WMASK;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			flags_ff <= `BSX_FLG_RESET;
		else
			flags_ff <= nxt_flags;
	end

	// Set 1 bank steering moves on the same edge as the flag, so no access sees a stale bank
	// Tied low where bank 1 is absent, since the flag alone must not steer to a missing bank
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			set1_bank_ff <= 1'b0;
		else
			set1_bank_ff <= nxt_flags[`BSX_FLG_BANK] & `BSX_BANK1_PRESENT;
	end

	// ----------------------------------------------------------------
	// Results
	// ----------------------------------------------------------------
	// Destination write-back only; the source has no write path at all
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			done_ff <= 1'b0;
			dst_we_ff <= 1'b0;
			dst_wdata_ff <= 8'h00;
		end
		else
		begin
			done_ff <= finish;
			dst_we_ff <= finish && (op_ff == bsx_pkg::op_sub_borrow);
			if (finish && (op_ff == bsx_pkg::op_sub_borrow))
				dst_wdata_ff <= alu_bus.res;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			busy_ff <= 1'b0;
		else
			busy_ff <= accept || ((state_ff == bsx_pkg::st_busy) && !finish);
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	// Data stands only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata_ff <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`BSX_REG_FLAGS: reg_rdata_ff <= flags_ff;
				`BSX_REG_STATUS: reg_rdata_ff <= {6'h00, set1_bank_ff, busy_ff};
				`BSX_REG_RESULT: reg_rdata_ff <= dst_wdata_ff;
				default: reg_rdata_ff <= 8'h00;
			endcase
		end
		else
			reg_rdata_ff <= 8'h00;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking chk_cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	logic issue_b0;
	logic issue_b1;
	logic issue_sbc;
	assign issue_b0 = accept && (nxt_op == bsx_pkg::op_sel_bank0);
	assign issue_b1 = accept && (nxt_op == bsx_pkg::op_sel_bank1);
	assign issue_sbc = accept && (nxt_op == bsx_pkg::op_sub_borrow);

	bank_zero_clear_a: assert property (issue_b0 |-> ##6 !flags_ff[`BSX_FLG_BANK])
		else $error("bank select not cleared six cycles after opcode 4F");

	bank_one_set_a: assert property (issue_b1 |-> ##6 flags_ff[`BSX_FLG_BANK])
		else $error("bank select not set six cycles after opcode 5F");

	// Counted from the cycle after accept: a reissue may be taken in the previous done cycle
	bank_done_time_a: assert property ((issue_b0 || issue_b1) |->
		##1 !done_ff[*5] ##1 done_ff)
		else $error("bank select instruction did not finish in six cycles");

	set1_steer_a: assert property (##1 (set1_bank_ff == (flags_ff[`BSX_FLG_BANK] & `BSX_BANK1_PRESENT)))
		else $error("set 1 bank steering does not follow bank select");

	bank_keeps_flags_a: assert property ((issue_b0 || issue_b1) ##5 1'b1 |=>
		(flags_ff[7:2] == $past(flags_ff[7:2])))
		else $error("bank select changed an arithmetic flag");

	sbc_result_a: assert property (finish && (op_ff == bsx_pkg::op_sub_borrow) |=>
		dst_we_ff && (dst_wdata_ff == $past(dst_ff - src_ff - {7'h00, flags_ff[`BSX_FLG_C]})))
		else $error("subtract result wrong");

	sbc_borrow_a: assert property (finish && (op_ff == bsx_pkg::op_sub_borrow) |=>
		flags_ff[`BSX_FLG_C] == ($past({1'b0, src_ff}) + $past({8'h00, flags_ff[`BSX_FLG_C]})
		> $past({1'b0, dst_ff})))
		else $error("carry does not show the borrow");

	sbc_zero_sign_a: assert property (dst_we_ff |->
		(flags_ff[`BSX_FLG_Z] == (dst_wdata_ff == 8'h00)) &&
		(flags_ff[`BSX_FLG_S] == dst_wdata_ff[7]))
		else $error("zero or sign flag disagrees with result");

	sbc_overflow_a: assert property (dst_we_ff |-> flags_ff[`BSX_FLG_V] ==
		(($past(dst_ff[7]) != $past(src_ff[7])) && (dst_wdata_ff[7] == $past(src_ff[7]))))
		else $error("overflow flag wrong");

	sbc_decimal_a: assert property (issue_sbc |-> ##6 flags_ff[`BSX_FLG_D])
		else $error("decimal adjust not forced after subtract");

	sbc_half_a: assert property (finish && (op_ff == bsx_pkg::op_sub_borrow) |=>
		flags_ff[`BSX_FLG_H] == ($past({1'b0, src_ff[3:0]}) + $past({4'h0, flags_ff[`BSX_FLG_C]})
		> $past({1'b0, dst_ff[3:0]})))
		else $error("half carry does not show nibble borrow");

	// The capture edge itself may change the source copy, so stability starts one cycle on
	sbc_src_kept_a: assert property (issue_sbc |-> ##2 $stable(src_ff)[*5])
		else $error("source operand changed during subtract");

	// Subtract completes on the same schedule and always writes the destination back
	sbc_done_time_a: assert property (issue_sbc |->
		##1 !done_ff[*5] ##1 (done_ff && dst_we_ff))
		else $error("subtract did not finish in six cycles");

	// Read data is a one-cycle answer; a stale value would look like a second read
	rd_zero_idle_a: assert property (!$past(reg_rd) |-> (reg_rdata_ff == 8'h00))
		else $error("read data present without a read strobe");

	// Bit 1 is cleared by the write mask on every write, so software can never park a value there
	flag_bit1_zero_a: assert property (!flags_ff[1])
		else $error("unused flag bit is set");

	// Busy drops in the done cycle so a held request can be taken there
	done_not_busy_a: assert property (done_ff |-> !busy_ff)
		else $error("busy still high at completion");

	// Main scenarios, including a bank request taken in the done cycle
	cover_bank0: cover property (issue_b0 ##6 done_ff);
	cover_bank1: cover property (issue_b1 ##6 set1_bank_ff);
	cover_sbc_borrow: cover property (issue_sbc ##6 flags_ff[`BSX_FLG_C]);
	cover_sbc_zero: cover property (issue_sbc ##6 flags_ff[`BSX_FLG_Z]);
	cover_bank_reissue: cover property (done_ff && issue_b0);
endmodule : bsx_core
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsx_cfg.svh"
module tb_top;
	// ----------------------------------------------------------------
	// Subtract cases: flags field is C Z S V D H
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic cin;
		logic [7:0] dst;
		logic [7:0] src;
		logic [7:0] res;
		logic [5:0] fl;
	} bsx_tb_row_t;
	// Row 4 keeps the borrow of row 3, as a chained high byte would
	localparam bsx_tb_row_t rows [8] = '{
		'{1'b1, 1'b1, 8'h10, 8'h03, 8'h0C, 6'b000011},
		'{1'b1, 1'b1, 8'h20, 8'h8A, 8'h95, 6'b101111},
		'{1'b1, 1'b0, 8'h05, 8'h05, 8'h00, 6'b010010},
		'{1'b1, 1'b1, 8'h00, 8'h00, 8'hFF, 6'b101011},
		'{1'b0, 1'b0, 8'h01, 8'h00, 8'h00, 6'b010010},
		'{1'b1, 1'b0, 8'h80, 8'h01, 8'h7F, 6'b000111},
		'{1'b1, 1'b0, 8'h7F, 8'hFF, 8'h80, 6'b101110},
		'{1'b1, 1'b0, 8'h3F, 8'h10, 8'h2F, 6'b000010}};

	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ins_valid = 1'b0;
	logic [7:0] ins_opcode = 8'h00;
	logic ins_sbc = 1'b0;
	logic [7:0] ins_dst = 8'h00;
	logic [7:0] ins_src = 8'h00;
	logic [7:0] reg_rdata_ff;
	logic busy_ff;
	logic done_ff;
	logic dst_we_ff;
	logic [7:0] dst_wdata_ff;
	logic [7:0] flags_ff;
	logic set1_bank_ff;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	int done_cnt = 0;
	int n;
	int seen;
	logic [7:0] rd;

	bsx_core bsx_core_inst (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_ff(reg_rdata_ff), .ins_valid(ins_valid), .ins_opcode(ins_opcode),
		.ins_sbc(ins_sbc), .ins_dst(ins_dst), .ins_src(ins_src), .busy_ff(busy_ff),
		.done_ff(done_ff), .dst_we_ff(dst_we_ff), .dst_wdata_ff(dst_wdata_ff),
		.flags_ff(flags_ff), .set1_bank_ff(set1_bank_ff));

	always #5 mclk = ~mclk;

	// Completion counter, so dropped requests can be shown to do nothing
	always @(posedge mclk)
	begin
		if (done_ff === 1'b1)
			done_cnt++;
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask : check

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr_reg

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_ff;
	endtask : rd_reg

	// Returns in the completion cycle with the count of edges since accept
	task automatic run(input logic sbc, input logic [7:0] op, input logic [7:0] d,
		input logic [7:0] s, output int cnt);
		@(posedge mclk);
		ins_valid <= 1'b1;
		ins_sbc <= sbc;
		ins_opcode <= op;
		ins_dst <= d;
		ins_src <= s;
		@(posedge mclk);
		ins_valid <= 1'b0;
		cnt = 1; // The accept edge is the first one counted
		do
		begin
			@(posedge mclk);
			#1 cnt++;
		end
		while (done_ff !== 1'b1 && cnt < 20);
	endtask : run

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		#1 check("reset flags", 8'h00, flags_ff);
		check("reset status", 8'h00, {5'h0, busy_ff, done_ff, set1_bank_ff});
		// Bit 1 is not writable; bank flag drives set 1 bank
		wr_reg(`BSX_REG_FLAGS, 8'hFF);
		rd_reg(`BSX_REG_FLAGS, rd);
		check("flags rd", 8'hFD, rd);
		check("set1 bank", 8'h01, {7'h0, set1_bank_ff});
		rd_reg(`BSX_REG_STATUS, rd);
		check("status rd", 8'h02, rd);
		@(posedge mclk);
		#1 check("rd stands", 8'h00, reg_rdata_ff);
		rd_reg(4'hF, rd);
		check("unmapped", 8'h00, rd);
		// Bank instructions touch only bit 0
		wr_reg(`BSX_REG_FLAGS, 8'hFC);
		run(1'b0, `BSX_OPC_SEL_BANK1, 8'h00, 8'h00, n);
		check("bank1 cycles", 8'd6, n[7:0]);
		check("bank1 flags", 8'hFD, flags_ff);
		check("bank1 set1", 8'h01, {7'h0, set1_bank_ff});
		check("bank1 we", 8'h00, {7'h0, dst_we_ff});
		wr_reg(`BSX_REG_FLAGS, 8'h01);
		run(1'b0, `BSX_OPC_SEL_BANK0, 8'h00, 8'h00, n);
		check("bank0 cycles", 8'd6, n[7:0]);
		check("bank0 flags", 8'h00, flags_ff);
		check("bank0 set1", 8'h00, {7'h0, set1_bank_ff});
		// Subtract table
		foreach (rows[i])
		begin
			if (rows[i].wr)
				wr_reg(`BSX_REG_FLAGS, {rows[i].cin, 7'h00});
			run(1'b1, 8'h00, rows[i].dst, rows[i].src, n);
			check("sbc cycles", 8'd6, n[7:0]);
			check("sbc we", 8'h01, {7'h0, dst_we_ff});
			check("sbc res", rows[i].res, dst_wdata_ff);
			check("flag c", {7'h0, rows[i].fl[5]}, {7'h0, flags_ff[7]});
			check("flag z", {7'h0, rows[i].fl[4]}, {7'h0, flags_ff[6]});
			check("flag s", {7'h0, rows[i].fl[3]}, {7'h0, flags_ff[5]});
			check("flag v", {7'h0, rows[i].fl[2]}, {7'h0, flags_ff[4]});
			check("flag d", 8'h01, {7'h0, flags_ff[3]});
			check("flag h", {7'h0, rows[i].fl[0]}, {7'h0, flags_ff[2]});
		end
		rd_reg(`BSX_REG_RESULT, rd);
		check("result reg", 8'h2F, rd);
		// A request while busy is dropped
		fork
			run(1'b0, `BSX_OPC_SEL_BANK1, 8'h00, 8'h00, n);
			begin
				repeat (3) @(posedge mclk);
				ins_valid <= 1'b1;
				ins_opcode <= `BSX_OPC_SEL_BANK0;
				#1 check("busy level", 8'h01, {7'h0, busy_ff});
				@(posedge mclk);
				ins_valid <= 1'b0;
			end
		join
		// The completion counter sees the done pulse one edge later
		@(posedge mclk);
		#1 seen = done_cnt;
		repeat (10) @(posedge mclk);
		#1 check("busy drop", 8'h01, {7'h0, flags_ff[0]});
		check("busy done", 8'd0, 8'(done_cnt - seen));
		// Unknown opcode does not complete
		@(posedge mclk);
		ins_valid <= 1'b1;
		ins_opcode <= 8'h00;
		@(posedge mclk);
		ins_valid <= 1'b0;
		repeat (10) @(posedge mclk);
		#1 check("unknown done", 8'd0, 8'(done_cnt - seen));
		// Held request is taken in the completion cycle
		@(posedge mclk);
		ins_valid <= 1'b1;
		@(posedge mclk);
		ins_opcode <= `BSX_OPC_SEL_BANK0;
		repeat (6) @(posedge mclk);
		@(posedge mclk);
		ins_valid <= 1'b0;
		repeat (5) @(posedge mclk);
		#1 check("b2b done", 8'h01, {7'h0, done_ff});
		check("b2b flags", 8'h00, {7'h0, flags_ff[0]});
		check("b2b set1", 8'h00, {7'h0, set1_bank_ff});
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
